// file: src/gsp_pkg.sv
// Constants and types shared by both ends of the gyro command link.
// Assumes a single 125 MHz clock in each end.
package gsp_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CMD_BITS      = 8;
  localparam int FRAME_BITS    = 16;
  localparam logic [7:0] CMD_RATE_HIGH  = 8'h80;
  localparam logic [7:0] CMD_RATE_LOW   = 8'h8e;
  localparam logic [7:0] CMD_TEMP       = 8'hb0;
  localparam logic [7:0] CMD_STATUS     = 8'hb4;
  localparam logic [7:0] CMD_DIS_ONE    = 8'h4e;
  localparam logic [7:0] ADDR_DIS_ONE   = 8'hd7;
  localparam logic [7:0] CMD_DIS_TWO    = 8'h63;
  localparam logic [7:0] ADDR_DIS_TWO   = 8'h50;
  localparam logic [7:0] CMD_DIS_THREE  = 8'h12;
  localparam logic [7:0] ADDR_DIS_THREE = 8'ha8;
  localparam logic [7:0] CMD_PROT_EN    = 8'h55;
  localparam logic [7:0] CMD_RESTART    = 8'haa;
  localparam logic [7:0] RESP_ERROR     = 8'h80;
  localparam logic [7:0] RESP_ENABLE    = 8'h00;
  localparam logic [3:0] LOW_CHECK      = 4'h5;
  localparam logic [11:0] RATE_MAX      = 12'h7f0;
  localparam logic [11:0] RATE_MIN      = 12'h810;
  localparam int SCLK_HALF_NS = 59;
  localparam int LEAD_NS      = 10;
  localparam int TAIL_NS      = 20;
  localparam int GAP_NS       = 527;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int LEAD_CYC = (LEAD_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  localparam int TAIL_CYC = (TAIL_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  localparam int GAP_CYC  = (GAP_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ONE, SEQ_TWO} gsp_seq_e;
  typedef enum logic [2:0] {
    H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP
  } gsp_host_e;
endpackage

// file: src/gsp_if.sv
// Serial pins between host and device ends.
// The testbench joins both ends through one instance.
`timescale 1ns/10ps
`default_nettype none
interface gsp_if;
  logic sclk;
  logic mosi;
  logic loadN;
  logic misoOut;
  logic misoOe;
  logic misoLine;
  assign misoLine = misoOe & misoOut;
  modport device (input sclk, input mosi, input loadN,
                  output misoOut, output misoOe);
  modport host (output sclk, output mosi, output loadN,
                input misoLine);
endinterface
`default_nettype wire

// file: src/gsp_device.sv
// Device end: command slave of the rate sensor.
// Assumes pins arrive asynchronously; sensor inputs are on clk.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Rate high returns sample top eight bits
// - Rate low returns 0101 and low nibble
// - Rate high latches low nibble, same sample
// - Eight command bits in, MSB first
// - Previous result shifted out during command
// - Output released while strobe high
// - Execute only after strobe rises
// - Fewer than eight bits discarded
// - Sample on rising, change on falling
// - Rate read codes, no address
// - Temperature and status read codes
// - Disable step one, ordered, with address
// - Disable step two code and address
// - Disable step three completes disable
// - Interruption or bad address restarts sequence
// - Enable command restores protection, answers zero
// - Restart clears error only when unprotected
// - Disable and restart answer 1000 0000
// - Overload error holds until restart
// - Error pattern at startup, illegal, bad status
// - Address byte precedes command byte
// - Clamp rate to plus minus 2032
module gsp_device
  import gsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  gsp_if.device            bus,
  input  wire logic [11:0] rateSample,
  input  wire logic [7:0]  temperature,
  input  wire logic [7:0]  statusByte,
  input  wire logic        sensorReady,
  input  wire logic        overloadEvent,
  output logic             protectDisabled,
  output logic             rateHalted,
  output logic             cmdStrobe,
  output logic [7:0]       cmdCode
);
  function automatic logic [11:0] clampRate(input logic [11:0] s);
    if (!s[11] && s > RATE_MAX)
      clampRate = RATE_MAX;
    else if (s[11] && s < RATE_MIN)
      clampRate = RATE_MIN;
    else
      clampRate = s;
  endfunction

  logic [2:0]  sclkSync;
  logic [2:0]  mosiSync;
  logic [2:0]  loadSync;
  logic        sclkF;
  logic        mosiF;
  logic        loadF;
  logic        sclkPrev;
  logic        loadPrev;
  logic        next_sclkF;
  logic        next_mosiF;
  logic        next_loadF;
  logic [15:0] rxShift;
  logic [4:0]  bitCnt;
  logic [7:0]  outShift;
  logic [7:0]  dataReg;
  logic [3:0]  lowLatch;
  gsp_seq_e    seqState;
  logic        next_misoOut;
  logic        next_misoOe;
  logic [15:0] next_rxShift;
  logic [4:0]  next_bitCnt;
  logic [7:0]  next_outShift;
  logic [7:0]  next_dataReg;
  logic [3:0]  next_lowLatch;
  gsp_seq_e    next_seqState;
  logic        next_protectDisabled;
  logic        next_rateHalted;
  logic        next_cmdStrobe;
  logic [7:0]  next_cmdCode;
  logic        sclkRise;
  logic        sclkFall;
  logic        loadFall;
  logic        loadRise;
  logic        rateBad;
  logic [11:0] clamped;
  logic [7:0]  cmd;
  logic [7:0]  addr;
  logic        hasAddr;
  logic        restartOk;

  assign sclkRise = sclkF & ~sclkPrev;
  assign sclkFall = ~sclkF & sclkPrev;
  assign loadFall = ~loadF & loadPrev;
  assign loadRise = loadF & ~loadPrev;
  assign clamped  = clampRate(rateSample);
  assign rateBad  = rateHalted | ~(&statusByte);
  assign cmd      = rxShift[7:0];
  assign addr     = rxShift[15:8];
  assign hasAddr  = bitCnt >= 5'(FRAME_BITS);

  always_comb
  begin
    next_sclkF = (sclkSync[2] == sclkSync[1]) ? sclkSync[1] : sclkF;
    next_mosiF = (mosiSync[2] == mosiSync[1]) ? mosiSync[1] : mosiF;
    next_loadF = (loadSync[2] == loadSync[1]) ? loadSync[1] : loadF;
  end

  always_comb
  begin
    next_misoOut         = bus.misoOut;
    next_misoOe          = ~loadF;
    next_rxShift         = rxShift;
    next_bitCnt          = bitCnt;
    next_outShift        = outShift;
    next_dataReg         = dataReg;
    next_lowLatch        = lowLatch;
    next_seqState        = seqState;
    next_protectDisabled = protectDisabled;
    next_cmdStrobe       = 1'b0;
    next_cmdCode         = cmdCode;
    restartOk            = 1'b0;
    if (loadFall)
    begin
      next_outShift = dataReg;
      next_misoOut  = dataReg[7];
      next_bitCnt   = '0;
    end
    else if (!loadF && sclkRise)
    begin
      next_rxShift = {rxShift[14:0], mosiF};
      if (bitCnt < 5'(FRAME_BITS))
        next_bitCnt = bitCnt + 5'd1;
    end
    else if (!loadF && sclkFall)
    begin
      next_outShift = {outShift[6:0], 1'b0};
      next_misoOut  = outShift[6];
    end
    if (loadRise && bitCnt >= 5'(CMD_BITS))
    begin
      next_cmdStrobe = 1'b1;
      next_cmdCode   = cmd;
      next_seqState  = SEQ_IDLE;
      next_dataReg   = RESP_ERROR;
      case (cmd)
        CMD_RATE_HIGH:
        begin
          if (!rateBad)
            next_dataReg = clamped[11:4];
          next_lowLatch = clamped[3:0];
        end
        CMD_RATE_LOW:
        begin
          if (!rateBad)
            next_dataReg = {LOW_CHECK, lowLatch};
        end
        CMD_TEMP:
          next_dataReg = temperature;
        CMD_STATUS:
          next_dataReg = statusByte;
        CMD_DIS_ONE:
        begin
          if (hasAddr && addr == ADDR_DIS_ONE)
            next_seqState = SEQ_ONE;
        end
        CMD_DIS_TWO:
        begin
          if (seqState == SEQ_ONE && hasAddr && addr == ADDR_DIS_TWO)
            next_seqState = SEQ_TWO;
        end
        CMD_DIS_THREE:
        begin
          if (seqState == SEQ_TWO && hasAddr && addr == ADDR_DIS_THREE)
            next_protectDisabled = 1'b1;
        end
        CMD_PROT_EN:
        begin
          next_protectDisabled = 1'b0;
          next_dataReg         = RESP_ENABLE;
        end
        CMD_RESTART:
          restartOk = protectDisabled;
        default:
          next_dataReg = RESP_ERROR;
      endcase
      if (!sensorReady)
        next_dataReg = RESP_ERROR;
    end
    next_rateHalted = overloadEvent | (rateHalted & ~restartOk);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclkSync <= 3'h0;
      mosiSync <= 3'h0;
      loadSync <= 3'h7;
      sclkF    <= 1'b0;
      mosiF    <= 1'b0;
      loadF    <= 1'b1;
      sclkPrev <= 1'b0;
      loadPrev <= 1'b1;
    end
    else
    begin
      sclkSync <= {sclkSync[1:0], bus.sclk};
      mosiSync <= {mosiSync[1:0], bus.mosi};
      loadSync <= {loadSync[1:0], bus.loadN};
      sclkF    <= next_sclkF;
      mosiF    <= next_mosiF;
      loadF    <= next_loadF;
      sclkPrev <= sclkF;
      loadPrev <= loadF;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus.misoOut     <= 1'b0;
      bus.misoOe      <= 1'b0;
      rxShift         <= 16'h0000;
      bitCnt          <= 5'h00;
      outShift        <= 8'h00;
      dataReg         <= RESP_ERROR;
      lowLatch        <= 4'h0;
      seqState        <= SEQ_IDLE;
      protectDisabled <= 1'b0;
      rateHalted      <= 1'b0;
      cmdStrobe       <= 1'b0;
      cmdCode         <= 8'h00;
    end
    else
    begin
      bus.misoOut     <= next_misoOut;
      bus.misoOe      <= next_misoOe;
      rxShift         <= next_rxShift;
      bitCnt          <= next_bitCnt;
      outShift        <= next_outShift;
      dataReg         <= next_dataReg;
      lowLatch        <= next_lowLatch;
      seqState        <= next_seqState;
      protectDisabled <= next_protectDisabled;
      rateHalted      <= next_rateHalted;
      cmdStrobe       <= next_cmdStrobe;
      cmdCode         <= next_cmdCode;
    end
  end
endmodule
`default_nettype wire

// file: src/gsp_host.sv
// Host end: issues one command frame per request, returns prior result.
// Assumes the request port is driven from clk.
`timescale 1ns/10ps
`default_nettype none
module gsp_host
  import gsp_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
)
(
  input  wire logic       clk,
  input  wire logic       resetn,
  gsp_if.host             bus,
  input  wire logic       reqValid,
  input  wire logic [7:0] reqCmd,
  input  wire logic [7:0] reqAddr,
  input  wire logic       reqHasAddr,
  output logic            busy,
  output logic            respValid,
  output logic [7:0]      respByte
);
  gsp_host_e   state;
  gsp_host_e   next_state;
  logic [7:0]  tmr;
  logic [7:0]  next_tmr;
  logic [4:0]  bitsLeft;
  logic [4:0]  next_bitsLeft;
  logic [15:0] txShift;
  logic [15:0] next_txShift;
  logic [7:0]  rxShift;
  logic [7:0]  next_rxShift;
  logic        longFrame;
  logic        next_longFrame;
  logic [2:0]  misoSync;
  logic        misoF;
  logic        next_misoF;
  logic        next_sclk;
  logic        next_mosi;
  logic        next_loadN;
  logic        next_busy;
  logic        next_respValid;
  logic [7:0]  next_respByte;

  always_comb
  begin
    next_misoF     = (misoSync[2] == misoSync[1]) ? misoSync[1] : misoF;
    next_state     = state;
    next_tmr       = (tmr != 8'h00) ? tmr - 8'd1 : tmr;
    next_bitsLeft  = bitsLeft;
    next_txShift   = txShift;
    next_rxShift   = rxShift;
    next_longFrame = longFrame;
    next_sclk      = bus.sclk;
    next_mosi      = bus.mosi;
    next_loadN     = bus.loadN;
    next_busy      = busy;
    next_respValid = 1'b0;
    next_respByte  = respByte;
    case (state)
      H_IDLE:
      begin
        if (reqValid)
        begin
          next_busy     = 1'b1;
          next_loadN    = 1'b0;
          next_txShift  = reqHasAddr ? {reqAddr, reqCmd} : {reqCmd, 8'h00};
          next_bitsLeft = reqHasAddr ? 5'(FRAME_BITS) : 5'(CMD_BITS);
          next_longFrame = reqHasAddr;
          next_tmr      = 8'(LEAD_CYC);
          next_state    = H_LEAD;
        end
      end
      H_LEAD:
      begin
        if (tmr == 8'h00)
        begin
          next_mosi    = txShift[15];
          next_txShift = {txShift[14:0], 1'b0};
          next_tmr     = 8'(HALF_CYC);
          next_state   = H_LOW;
        end
      end
      H_LOW:
      begin
        if (tmr == 8'h00)
        begin
          next_sclk  = 1'b1;
          next_tmr   = 8'(HALF_CYC);
          next_state = H_HIGH;
        end
      end
      H_HIGH:
      begin
        if (tmr == 8'h00)
        begin
          next_sclk     = 1'b0;
          next_bitsLeft = bitsLeft - 5'd1;
          // Only the first eight bits carry the prior result
          if (!longFrame || bitsLeft > 5'(FRAME_BITS - CMD_BITS))
            next_rxShift = {rxShift[6:0], misoF};
          next_tmr = 8'(HALF_CYC);
          if (bitsLeft == 5'd1)
          begin
            next_tmr   = 8'(TAIL_CYC);
            next_state = H_TAIL;
          end
          else
          begin
            next_mosi    = txShift[15];
            next_txShift = {txShift[14:0], 1'b0};
            next_state   = H_LOW;
          end
        end
      end
      H_TAIL:
      begin
        if (tmr == 8'h00)
        begin
          next_loadN     = 1'b1;
          next_respValid = 1'b1;
          next_respByte  = rxShift;
          next_tmr       = 8'(GAP_CYC);
          next_state     = H_GAP;
        end
      end
      H_GAP:
      begin
        if (tmr == 8'h00)
        begin
          next_busy  = 1'b0;
          next_state = H_IDLE;
        end
      end
      default:
        next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      misoSync  <= 3'h0;
      misoF     <= 1'b0;
      state     <= H_IDLE;
      tmr       <= 8'h00;
      bitsLeft  <= 5'h00;
      txShift   <= 16'h0000;
      rxShift   <= 8'h00;
      longFrame <= 1'b0;
      bus.sclk  <= 1'b0;
      bus.mosi  <= 1'b0;
      bus.loadN <= 1'b1;
      busy      <= 1'b0;
      respValid <= 1'b0;
      respByte  <= 8'h00;
    end
    else
    begin
      misoSync  <= {misoSync[1:0], bus.misoLine};
      misoF     <= next_misoF;
      state     <= next_state;
      tmr       <= next_tmr;
      bitsLeft  <= next_bitsLeft;
      txShift   <= next_txShift;
      rxShift   <= next_rxShift;
      longFrame <= next_longFrame;
      bus.sclk  <= next_sclk;
      bus.mosi  <= next_mosi;
      bus.loadN <= next_loadN;
      busy      <= next_busy;
      respValid <= next_respValid;
      respByte  <= next_respByte;
    end
  end
endmodule
`default_nettype wire

// file: tb/gsp_checker.sv
// Assertions on the serial pins between the two ends.
// Assumes one clock; takes the interface signals as plain inputs.
`timescale 1ns/10ps
`default_nettype none
module gsp_checker
  import gsp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic loadN,
  input wire logic misoOut,
  input wire logic misoOe
);
  logic [4:0] nRise;
  logic [4:0] next_nRise;
  logic [6:0] nHigh;
  logic [6:0] next_nHigh;
  logic       prevSclk;
  logic       next_prevSclk;

  // Rising serial edges per frame, idle cycles between frames
  always_comb
  begin
    next_prevSclk = sclk;
    next_nRise = loadN ? 5'h00 : nRise + 5'(sclk & ~prevSclk);
    next_nHigh = nHigh;
    if (!loadN)
      next_nHigh = 7'h00;
    else if (nHigh < 7'(GAP_CYC))
      next_nHigh = nHigh + 7'h01;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      nRise    <= 5'h00;
      nHigh    <= 7'(GAP_CYC);
      prevSclk <= 1'b0;
    end
    else
    begin
      nRise    <= next_nRise;
      nHigh    <= next_nHigh;
      prevSclk <= next_prevSclk;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  hiz_idle_a: assert property (loadN [*8] |-> !misoOe)
    else $error("miso driven while strobe high");
  oe_on_a: assert property ($fell(loadN) |-> ##[1:8] misoOe)
    else $error("miso not driven after strobe fall");
  oe_off_a: assert property ($rose(loadN) |-> ##[1:8] !misoOe)
    else $error("miso not released after strobe rise");
  mosi_hold_a: assert property (sclk |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  sclk_idle_a: assert property (loadN |-> !sclk)
    else $error("sclk high outside frame");
  lead_time_a: assert property ($fell(loadN) |-> !sclk [*3])
    else $error("sclk too soon after strobe fall");
  bit_count_a: assert property ($rose(loadN) |->
    (nRise == 5'd8 || nRise == 5'd16))
    else $error("frame bit count wrong");
  gap_time_a: assert property ($fell(loadN) |->
    nHigh >= 7'(GAP_CYC))
    else $error("gap between frames too short");
  tail_time_a: assert property ($rose(loadN) |-> !$past(sclk, 3))
    else $error("strobe rose too soon after sclk");
  miso_stable_a: assert property ($rose(sclk) && misoOe |->
    $stable(misoOut) [*3])
    else $error("miso moved near sclk rise");
endmodule
`default_nettype wire

// file: tb/gsp_tb.sv
// Bench: host and device joined, plus a second device bit-banged.
// Assumes package, interface and both ends compiled first.
`timescale 1ns/10ps
`default_nettype none
module gyro_spi_command_port_tb
  import gsp_pkg::*;
;
  logic        clk;
  logic        resetn = 1'b0;
  logic        reqValid = 1'b0;
  logic        reqHas = 1'b0;
  logic        ready = 1'b0;
  logic        ovl = 1'b0;
  logic [7:0]  reqCmd = 8'h00;
  logic [7:0]  reqAddr = 8'h00;
  logic [11:0] rate = 12'h000;
  logic [7:0]  temp = 8'h19;
  logic [7:0]  stat = 8'hff;
  logic        busy;
  logic        respValid;
  logic        protDis;
  logic        halted;
  logic        strobe;
  logic        strobe2;
  logic [7:0]  respByte;
  logic [7:0]  code;
  logic [7:0]  code2;
  logic [7:0]  got;
  logic [15:0] wireWord = 16'h0000;
  logic [31:0] seed = 32'd94;
  int          wireBits;
  int          nStrobe;
  int          nStrobe2;
  int          nFrames;
  int          nErrors;
  int          nCompared;
  logic [7:0]  mResp = RESP_ERROR;
  logic [1:0]  mSeq = 2'h0;
  logic        mDis = 1'b0;
  logic        mHalt = 1'b0;
  logic [3:0]  mNib = 4'h0;
  localparam logic [15:0] SEQ [21] = '{
    {CMD_DIS_ONE, ADDR_DIS_ONE}, {CMD_TEMP, 8'h00},
    {CMD_DIS_TWO, ADDR_DIS_TWO}, {CMD_DIS_THREE, ADDR_DIS_THREE},
    {CMD_DIS_ONE, 8'h00}, {CMD_DIS_TWO, ADDR_DIS_TWO},
    {CMD_DIS_THREE, ADDR_DIS_THREE}, {CMD_DIS_ONE, ADDR_DIS_ONE},
    {CMD_DIS_TWO, 8'h51}, {CMD_DIS_THREE, ADDR_DIS_THREE},
    {CMD_RESTART, 8'h00}, {CMD_RATE_HIGH, 8'h00},
    {CMD_DIS_ONE, ADDR_DIS_ONE}, {CMD_DIS_TWO, ADDR_DIS_TWO},
    {CMD_DIS_THREE, ADDR_DIS_THREE}, {CMD_RESTART, 8'h00},
    {CMD_RATE_HIGH, 8'h00}, {CMD_PROT_EN, 8'h00},
    {CMD_PROT_EN, 8'h00}, {8'h01, 8'h00}, {CMD_STATUS, 8'h00}};

  gsp_if bus ();
  gsp_if bus2 ();
  gsp_host u_gsp_host (.clk(clk), .resetn(resetn), .bus(bus.host),
    .reqValid(reqValid), .reqCmd(reqCmd), .reqAddr(reqAddr),
    .reqHasAddr(reqHas), .busy(busy), .respValid(respValid),
    .respByte(respByte));
  gsp_device u_gsp_device (.clk(clk), .resetn(resetn),
    .bus(bus.device), .rateSample(rate), .temperature(temp),
    .statusByte(stat), .sensorReady(ready), .overloadEvent(ovl),
    .protectDisabled(protDis), .rateHalted(halted),
    .cmdStrobe(strobe), .cmdCode(code));
  gsp_device u_gsp_device2 (.clk(clk), .resetn(resetn),
    .bus(bus2.device), .rateSample(rate), .temperature(temp),
    .statusByte(stat), .sensorReady(ready), .overloadEvent(ovl),
    .protectDisabled(), .rateHalted(), .cmdStrobe(strobe2),
    .cmdCode(code2));
  gsp_checker u_gsp_checker (.clk(clk), .resetn(resetn),
    .sclk(bus.sclk), .mosi(bus.mosi), .loadN(bus.loadN),
    .misoOut(bus.misoOut), .misoOe(bus.misoOe));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Bits seen on the host wire, strobes of both devices
  always @(negedge bus.loadN) wireBits = 0;
  always @(posedge bus.sclk)
  begin
    wireWord = {wireWord[14:0], bus.mosi};
    wireBits++;
  end
  always @(negedge clk)
  begin
    if (strobe === 1'b1) nStrobe++;
    if (strobe2 === 1'b1) nStrobe2++;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Reference behaviour of one executed command
  task automatic model(input logic [7:0] c, input logic [7:0] a);
    logic [11:0] s;
    logic [1:0]  q;
    logic        bad;
    s = rate;
    if ($signed(rate) > 2032) s = RATE_MAX;
    if ($signed(rate) < -2032) s = RATE_MIN;
    bad = mHalt || stat !== 8'hff;
    q = 2'h0;
    mResp = RESP_ERROR;
    case (c)
      CMD_RATE_HIGH:
      begin
        mNib = s[3:0];
        if (!bad) mResp = s[11:4];
      end
      CMD_RATE_LOW: if (!bad) mResp = {LOW_CHECK, mNib};
      CMD_TEMP: mResp = temp;
      CMD_STATUS: mResp = stat;
      CMD_PROT_EN:
      begin
        mDis = 1'b0;
        mResp = RESP_ENABLE;
      end
      CMD_RESTART: if (mDis) mHalt = 1'b0;
      CMD_DIS_ONE: if (a == ADDR_DIS_ONE) q = 2'h1;
      CMD_DIS_TWO: if (a == ADDR_DIS_TWO && mSeq == 2'h1) q = 2'h2;
      CMD_DIS_THREE: if (a == ADDR_DIS_THREE && mSeq == 2'h2) mDis = 1'b1;
      default: mResp = RESP_ERROR;
    endcase
    mSeq = q;
    if (!ready) mResp = RESP_ERROR;
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] a);
    logic has;
    int   n;
    has = c == CMD_DIS_ONE || c == CMD_DIS_TWO || c == CMD_DIS_THREE;
    n = 0;
    @(posedge clk);
    reqValid <= 1'b1;
    reqCmd <= c;
    reqAddr <= a;
    reqHas <= has;
    @(posedge clk);
    reqValid <= 1'b0;
    while (respValid !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    chk(respByte, mResp);
    chk(wireWord[7:0], c);
    if (has) chk(wireWord[15:8], a);
    chk(8'(wireBits), has ? 8'd16 : 8'd8);
    model(c, a);
    nFrames++;
    while (busy !== 1'b0 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000)
    begin
      nErrors++;
      $display("[FAIL] %0t host response timeout", $time);
    end
    chk({7'h0, protDis}, {7'h0, mDis});
    chk({7'h0, halted}, {7'h0, mHalt});
    chk(code, c);
    chk(8'(nStrobe), 8'(nFrames));
  endtask

  // Bit-banged frame of nb bits into the second device
  task automatic bang(input logic [7:0] c, input int nb);
    got = 8'h00;
    @(posedge clk);
    bus2.loadN <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      bus2.mosi <= c[7 - i];
      repeat (9) @(posedge clk);
      bus2.sclk <= 1'b1;
      got[7 - i] = bus2.misoLine;
      repeat (9) @(posedge clk);
      bus2.sclk <= 1'b0;
    end
    repeat (3) @(posedge clk);
    bus2.loadN <= 1'b1;
    repeat (80) @(posedge clk);
  endtask

  initial
  begin
    bus2.sclk <= 1'b0;
    bus2.mosi <= 1'b0;
    bus2.loadN <= 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    cmd(CMD_TEMP, 8'h00);
    cmd(CMD_STATUS, 8'h00);
    @(posedge clk);
    ready <= 1'b1;
    $display("test startup done");
    for (int i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      @(posedge clk);
      rate <= i == 0 ? 12'h7ff : i == 1 ? 12'h800 : seed[11:0];
      temp <= seed[19:12];
      cmd(CMD_RATE_HIGH, 8'h00);
      @(posedge clk);
      rate <= seed[31:20];
      cmd(CMD_RATE_LOW, 8'h00);
      cmd(CMD_TEMP, 8'h00);
    end
    @(posedge clk);
    stat <= 8'hfe;
    cmd(CMD_RATE_HIGH, 8'h00);
    cmd(CMD_RATE_LOW, 8'h00);
    @(posedge clk);
    stat <= 8'hff;
    $display("test rate reads done");
    for (int k = 0; k < 21; k++)
    begin
      if (k == 10)
      begin
        @(posedge clk);
        ovl <= 1'b1;
        @(posedge clk);
        ovl <= 1'b0;
        mHalt = 1'b1;
      end
      cmd(SEQ[k][15:8], SEQ[k][7:0]);
    end
    $display("test protection done");
    bang(CMD_PROT_EN, 5);
    bang(CMD_TEMP, 8);
    chk(got, RESP_ERROR);
    bang(CMD_STATUS, 8);
    chk(got, temp);
    chk(8'(nStrobe2), 8'd2);
    chk(code2, CMD_STATUS);
    $display("test partial frame done");
    tally_and_finish();
  end

  initial
  begin
    #500000;
    nErrors++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
